/* File: bench/sacr_monitor.sv */
// port checker for the secure aux control register
`timescale 1ns/1ps
module sacr_monitor (
  // clock and reset
  input wire CLK,
  input wire RESET_N,
  // bus
  input wire BVALID,
  input wire BREADY,
  input wire [1:0] BRESP,
  input wire ARVALID,
  input wire ARREADY,
  input wire RVALID,
  input wire RREADY,
  input wire [31:0] RDATA,
  // control side
  input wire XLAT_OFF_START,
  input wire XLAT_OFF_HIT,
  input wire XLAT_OFF_DONE,
  input wire XLAT_OFF_TLB_CACHE_EN,
  input wire [7:0] ATTR_IN,
  input wire [7:0] ATTR_OUT,
  input wire [31:0] MAP_PAGE_BYTES,
  input wire CTX_AUX_WRITABLE_SEC,
  input wire CTX_AUX_WRITABLE_NS,
  input wire NS_CACHE_LOCK
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  // ********
  // checks
  // ********
  sequence s_fast;
    XLAT_OFF_START && XLAT_OFF_HIT && XLAT_OFF_TLB_CACHE_EN;
  endsequence
  sequence s_slow;
    XLAT_OFF_START && !(XLAT_OFF_HIT && XLAT_OFF_TLB_CACHE_EN);
  endsequence
  a_hit_fast: assert property (s_fast |-> ##6 XLAT_OFF_DONE)
    else $error("cached finish late");
  a_slow_path: assert property (s_slow |=> !XLAT_OFF_DONE [*8] ##4 XLAT_OFF_DONE)
    else $error("uncached finish early");
  a_b_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped");
  a_r_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped");
  a_ar_block: assert property (ARVALID && ARREADY |=> !ARREADY)
    else $error("second read taken");
  a_wb_pass: assert property (ATTR_IN == 8'hFF |=> ATTR_OUT == 8'hFF)
    else $error("write-back attr changed");
  a_ns_lock: assert property (NS_CACHE_LOCK |=> !CTX_AUX_WRITABLE_NS)
    else $error("ns lock ignored");
  a_lock_order: assert property (CTX_AUX_WRITABLE_NS |-> CTX_AUX_WRITABLE_SEC)
    else $error("ns open while sec locked");
  a_page_legal: assert property (MAP_PAGE_BYTES == 32'h1000 || MAP_PAGE_BYTES == 32'h10000)
    else $error("bad page size");
endmodule

/* File: bench/testbench.sv */
// self-checking bench for the secure aux control register
`timescale 1ns/1ps
`include "sacr_defs.vh"
module testbench;
  reg CLK, RESET_N, CFG_NORMALIZE, AWVALID, WVALID, BREADY, ARVALID, RREADY;
  reg XLAT_OFF_START, XLAT_OFF_HIT, NS_CACHE_LOCK;
  reg [11:0] AWADDR, ARADDR;
  reg [31:0] WDATA, m;
  reg [3:0] WSTRB, cnt;
  reg [7:0] ATTR_IN, a;
  wire AWREADY, WREADY, BVALID, ARREADY, RVALID, XLAT_OFF_DONE, XLAT_OFF_TLB_CACHE_EN;
  wire CTX_BYPASS_TLB_CACHE_EN, NOMATCH_TLB_CACHE_EN, STAGE1_WALK_CACHE2_EN;
  wire CTX_AUX_WRITABLE_SEC, CTX_AUX_WRITABLE_NS;
  wire [1:0] BRESP, RRESP;
  wire [31:0] RDATA, MAP_PAGE_BYTES;
  wire [7:0] ATTR_OUT;
  integer err_total = 0, checked = 0, cyc = 0, i, j, k, n0, n1;
  reg [1:0] bq[$];
  reg [33:0] rq[$];
  sacr_top dut (.*);
  // ********
  // tasks
  // ********
  task automatic cmp(input string n, input [33:0] e, input [33:0] g);
    begin
      checked++;
      if (g !== e) begin
        err_total++;
        $display("BAD %s exp %h got %h", n, e, g);
      end
    end
  endtask
  task conclude;
    begin
      if (err_total == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // write with late bready; address and data each released once taken
  task wr(input [11:0] ad, input [31:0] d, input [3:0] s, input [1:0] r);
    reg aw_ok, w_ok;
    begin
      bq.push_back(r);
      AWADDR <= ad;
      WDATA <= d;
      WSTRB <= s;
      AWVALID <= 1'b1;
      WVALID <= 1'b1;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      while (!aw_ok || !w_ok) begin
        @(posedge CLK);
        if (!aw_ok && AWREADY === 1'b1) begin
          aw_ok = 1'b1;
          AWVALID <= 1'b0;
        end
        if (!w_ok && WREADY === 1'b1) begin
          w_ok = 1'b1;
          WVALID <= 1'b0;
        end
      end
      repeat (2) @(posedge CLK);
      BREADY <= 1'b1;
      do @(posedge CLK); while (BVALID !== 1'b1);
      BREADY <= 1'b0;
    end
  endtask
  // read with late rready
  task rd(input [11:0] ad, input [33:0] e);
    begin
      rq.push_back(e);
      ARADDR <= ad; ARVALID <= 1;
      do @(posedge CLK); while (ARREADY !== 1'b1);
      ARVALID <= 0;
      @(posedge CLK);
      RREADY <= 1;
      do @(posedge CLK); while (RVALID !== 1'b1);
      RREADY <= 0;
    end
  endtask
  task outs;
    begin
      repeat (3) @(posedge CLK);
      cmp("page", m[16] ? 32'h10000 : 32'h1000, MAP_PAGE_BYTES);
      cmp("en", {m[10], m[9], m[8], m[2], ~m[26], ~m[26] & ~NS_CACHE_LOCK}, {CTX_BYPASS_TLB_CACHE_EN,
        XLAT_OFF_TLB_CACHE_EN, NOMATCH_TLB_CACHE_EN, STAGE1_WALK_CACHE2_EN, CTX_AUX_WRITABLE_SEC,
        CTX_AUX_WRITABLE_NS});
    end
  endtask
  // control write, model merge, read back
  task w0(input [31:0] d, input [3:0] s);
    begin
      NS_CACHE_LOCK <= 1'($urandom);
      wr(12'h000, d, s, 2'h0);
      for (j = 0; j < 4; j++) if (s[j]) m[j*8+:8] = (m[j*8+:8] & ~`SACR_WMASK >> j*8) | (d[j*8+:8] & `SACR_WMASK >> j*8);
      rd(12'h000, {2'h0, m});
      outs;
    end
  endtask
  task xl(input h, output integer n);
    begin
      XLAT_OFF_START <= 1; XLAT_OFF_HIT <= h;
      @(posedge CLK);
      XLAT_OFF_START <= 0;
      n = 0;
      while (XLAT_OFF_DONE !== 1'b1) begin @(posedge CLK); n++; end
      cnt++;
      repeat (2) @(posedge CLK);
    end
  endtask
  // queued response compare and timeout
  always @(posedge CLK) begin
    if (BVALID && BREADY) cmp("bresp", bq.pop_front(), BRESP);
    if (RVALID && RREADY) cmp("read", rq.pop_front(), {RRESP, RDATA});
    cyc++;
    if (cyc > 20000) begin err_total++; conclude; end
  end
  initial begin CLK = 0; forever #10 CLK = ~CLK; end
  // main sequence
  initial begin
    CFG_NORMALIZE = 1'($urandom(67));
    {RESET_N, AWVALID, WVALID, BREADY, ARVALID, RREADY, XLAT_OFF_START, XLAT_OFF_HIT, NS_CACHE_LOCK} = 0;
    {AWADDR, ARADDR, WDATA, WSTRB, ATTR_IN, cnt} = 0;
    repeat (3) @(posedge CLK);
    RESET_N <= 1;
    repeat (3) @(posedge CLK);
    m = 32'h04000004 | {CFG_NORMALIZE, 27'h0};
    rd(12'h000, {2'h0, m});
    outs;
    w0(32'hFFFFFFFF, 4'hF);
    for (i = 0; i < 6; i++) w0($urandom, 4'($urandom));
    rd(12'h008, {2'h2, 32'h0});
    wr(12'h010, 32'hFFFFFFFF, 4'hF, 2'h2);
    wr(12'h004, 32'hFFFFFFFF, 4'hF, 2'h0);
    rd(12'h000, {2'h0, m});
    for (k = 0; k < 2; k++) begin
      w0({4'h0, k[0], 17'h0, k[0], 9'h0}, 4'hF);
      for (j = 0; j < 2; j++) begin
        a = j ? 8'hFF : 8'($urandom);
        ATTR_IN <= a;
        repeat (2) @(posedge CLK);
        cmp("attr", (k && a != 8'hFF) ? 8'h44 : a, ATTR_OUT);
      end
      xl(0, n0);
      xl(1, n1);
      cmp("saved", k ? 6 : 0, n0 - n1);
    end
    rd(12'h004, {30'h0, cnt});
    // second reset with the strap flipped: normalize bit takes the new level
    CFG_NORMALIZE <= ~CFG_NORMALIZE;
    RESET_N <= 1'b0;
    repeat (3) @(posedge CLK);
    RESET_N <= 1'b1;
    repeat (3) @(posedge CLK);
    m = 32'h04000004 | {CFG_NORMALIZE, 27'h0};
    rd(12'h000, {2'h0, m});
    rd(12'h004, 34'h0);
    outs;
    conclude;
  end
endmodule
bind sacr_top sacr_monitor mon (.*);

/* File: src/sacr_bypass_timer.v */
// latency counter for translation-disabled bypass transactions
`timescale 1ns/1ps
`include "sacr_defs.vh"
module sacr_bypass_timer (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // transaction
  input wire start,
  input wire cached_hit,
  output reg done
);
  reg [3:0] cnt_r;
  reg busy_r;
  // count down; a cached hit skips the saved cycles
  always @(posedge clk) begin
    if (!reset_n) begin
      cnt_r <= 4'h0;
      busy_r <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy_r) begin
        busy_r <= 1'b1;
        cnt_r <= cached_hit ? (`SACR_BYPASS_CYCLES - `SACR_SAVED_CYCLES) : `SACR_BYPASS_CYCLES;
      end else if (busy_r) begin
        if (cnt_r == 4'h1) begin
          busy_r <= 1'b0;
          done <= 1'b1;
        end
        cnt_r <= cnt_r - 4'h1;
      end
    end
  end
endmodule

/* File: src/sacr_defs.vh */
// constants for the secure auxiliary control register block
`ifndef SACR_DEFS_VH
`define SACR_DEFS_VH
`define SACR_OFF_CTRL 12'h000
`define SACR_OFF_STATUS 12'h004
`define SACR_BIT_NORMALIZE 27
`define SACR_BIT_CACHE_LOCK 26
`define SACR_BIT_PAGE_SIZE 16
`define SACR_BIT_CTX_BYP 10
`define SACR_BIT_XLAT_OFF 9
`define SACR_BIT_NOMATCH 8
`define SACR_BIT_WC2 2
`define SACR_WMASK 32'h0C010704
`define SACR_RESET_FIXED 32'h04000004
`define SACR_PAGE_4K 32'h00001000
`define SACR_PAGE_64K 32'h00010000
`define SACR_BYPASS_CYCLES 4'hA
`define SACR_SAVED_CYCLES 4'h6
`define SACR_RESP_OKAY 2'h0
`define SACR_RESP_SLVERR 2'h2
`endif

/* File: src/sacr_top.v */
// secure auxiliary control register with AXI4-Lite slave
// Function
// - bit 16 selects 64KB or 4KB pages
// - bit 10 enables context bypass TLB caching
// - bit 9 enables translation-off TLB caching
// - cached translation-off hit finishes six cycles sooner
// - bit 8 enables no-match TLB caching
// - bit 2 enables stage 1 walk cache 2
// - normalize bit reset value from config input
// - bit 27 normalizes non-writeback attributes
// - bit 26 lock makes context aux registers read-only
//
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "sacr_defs.vh"
module sacr_top (
  // clock and reset
  input wire CLK,
  input wire RESET_N,
  // normalization strap
  input wire CFG_NORMALIZE,
  // axi4-lite write address
  input wire [11:0] AWADDR,
  input wire AWVALID,
  output reg AWREADY,
  // axi4-lite write data
  input wire [31:0] WDATA,
  input wire [3:0] WSTRB,
  input wire WVALID,
  output reg WREADY,
  // axi4-lite write response
  output reg [1:0] BRESP,
  output reg BVALID,
  input wire BREADY,
  // axi4-lite read address
  input wire [11:0] ARADDR,
  input wire ARVALID,
  output reg ARREADY,
  // axi4-lite read data
  output reg [31:0] RDATA,
  output reg [1:0] RRESP,
  output reg RVALID,
  input wire RREADY,
  // bypass transaction timing
  input wire XLAT_OFF_START,
  input wire XLAT_OFF_HIT,
  output reg XLAT_OFF_DONE,
  // attribute path
  input wire [7:0] ATTR_IN,
  output reg [7:0] ATTR_OUT,
  // control outputs
  output reg [31:0] MAP_PAGE_BYTES,
  output reg CTX_BYPASS_TLB_CACHE_EN,
  output reg XLAT_OFF_TLB_CACHE_EN,
  output reg NOMATCH_TLB_CACHE_EN,
  output reg STAGE1_WALK_CACHE2_EN,
  output reg CTX_AUX_WRITABLE_SEC,
  output reg CTX_AUX_WRITABLE_NS,
  // nonsecure lock input from nonsecure aux control
  input wire NS_CACHE_LOCK
);

  // **********
  // register state
  // **********
  reg [31:0] ctrl_r;
  reg [31:0] ctrl_nxt;
  reg strap_r;
  reg strap_done_r;
  // write channel holding registers
  reg [11:0] awaddr_r;
  reg aw_have_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  reg w_have_r;
  // wrapping count of finished translation-off transactions
  reg [3:0] xlat_cnt_r;
  wire [31:0] merged;
  wire timer_done;
  wire normalize;
  // channel events and read data mux
  wire wr_fire;
  wire b_done;
  wire ar_fire;
  wire r_done;
  reg [31:0] rdata_nxt;
  reg [1:0] rresp_nxt;

  assign normalize = ctrl_r[`SACR_BIT_NORMALIZE];

  // attribute is write-back inner and outer when both nibbles are 4'hF
  function is_wb;
    input [7:0] a;
    begin
      is_wb = (a[7:4] == 4'hF) && (a[3:0] == 4'hF);
    end
  endfunction

  // address decode shared by the write and read paths
  function addr_is_ctrl;
    input [11:0] a;
    begin
      addr_is_ctrl = (a == `SACR_OFF_CTRL);
    end
  endfunction

  // status word: count of finished translation-off transactions
  function addr_is_status;
    input [11:0] a;
    begin
      addr_is_status = (a == `SACR_OFF_STATUS);
    end
  endfunction

  // **********
  // write path
  // **********
  sacr_wstrb_merge u_merge (
    .old_val(ctrl_r),
    .wdata(wdata_r),
    .wstrb(wstrb_r),
    .wmask(`SACR_WMASK),
    .new_val(merged)
  );

  // handshake events of the write and read channels
  assign wr_fire = aw_have_r && w_have_r && !BVALID;
  assign b_done = BVALID && BREADY;
  assign ar_fire = ARVALID && ARREADY;
  assign r_done = RVALID && RREADY;

  // next control value on a completed write; other offsets leave it alone
  always @* begin
    ctrl_nxt = ctrl_r;
    if (wr_fire && addr_is_ctrl(awaddr_r))
      ctrl_nxt = merged & `SACR_WMASK;
  end

  // write address: one held at a time until its response is taken
  always @(posedge CLK) begin
    if (!RESET_N) begin
      AWREADY <= 1'b1;
      aw_have_r <= 1'b0;
      awaddr_r <= 12'h000;
    end else if (b_done) begin
      AWREADY <= 1'b1;
      aw_have_r <= 1'b0;
    end else if (AWVALID && AWREADY) begin
      AWREADY <= 1'b0;
      aw_have_r <= 1'b1;
      awaddr_r <= AWADDR;
    end
  end

  // write data: may arrive before or after its address
  always @(posedge CLK) begin
    if (!RESET_N) begin
      WREADY <= 1'b1;
      w_have_r <= 1'b0;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
    end else if (b_done) begin
      WREADY <= 1'b1;
      w_have_r <= 1'b0;
    end else if (WVALID && WREADY) begin
      WREADY <= 1'b0;
      w_have_r <= 1'b1;
      wdata_r <= WDATA;
      wstrb_r <= WSTRB;
    end
  end

  // write response: raised once both halves are held, kept until taken
  always @(posedge CLK) begin
    if (!RESET_N) begin
      BVALID <= 1'b0;
      BRESP <= `SACR_RESP_OKAY;
    end else if (wr_fire) begin
      BVALID <= 1'b1;
      // unmapped offsets answer with an error and change nothing
      BRESP <= (addr_is_ctrl(awaddr_r) || addr_is_status(awaddr_r)) ? `SACR_RESP_OKAY : `SACR_RESP_SLVERR;
    end else if (b_done) begin
      BVALID <= 1'b0;
    end
  end

  // control register; normalize bit caught from the strap during reset
  always @(posedge CLK) begin
    if (!RESET_N) begin
      ctrl_r <= `SACR_RESET_FIXED;
      strap_done_r <= 1'b0;
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      ctrl_r <= {ctrl_r[31:28], strap_r, ctrl_r[26:0]};
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // strap sampled on every reset cycle
  always @(posedge CLK) begin
    if (!RESET_N)
      strap_r <= CFG_NORMALIZE;
  end

  // **********
  // read path
  // **********
  // read data chosen by address; unmapped space reads zero with an error
  always @* begin
    rdata_nxt = 32'h00000000;
    rresp_nxt = `SACR_RESP_SLVERR;
    if (addr_is_ctrl(ARADDR)) begin
      rdata_nxt = ctrl_r & `SACR_WMASK;
      rresp_nxt = `SACR_RESP_OKAY;
    end else if (addr_is_status(ARADDR)) begin
      // the count wraps after sixteen completions
      rdata_nxt = {28'h0000000, xlat_cnt_r};
      rresp_nxt = `SACR_RESP_OKAY;
    end
  end

  // read address taken one at a time; data held until the master takes it
  always @(posedge CLK) begin
    if (!RESET_N) begin
      ARREADY <= 1'b1;
      RVALID <= 1'b0;
      RDATA <= 32'h00000000;
      RRESP <= `SACR_RESP_OKAY;
    end else if (ar_fire) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b1;
      RDATA <= rdata_nxt;
      RRESP <= rresp_nxt;
    end else if (r_done) begin
      RVALID <= 1'b0;
      ARREADY <= 1'b1;
    end
  end

  // **********
  // steered logic
  // **********
  // translation-off latency; a hit only shortens it while caching is on
  sacr_bypass_timer u_timer (
    .clk(CLK),
    .reset_n(RESET_N),
    .start(XLAT_OFF_START),
    .cached_hit(XLAT_OFF_HIT & ctrl_r[`SACR_BIT_XLAT_OFF]),
    .done(timer_done)
  );

  // page size and caching enables follow the control word one cycle later
  always @(posedge CLK) begin
    if (!RESET_N) begin
      MAP_PAGE_BYTES <= `SACR_PAGE_4K;
      CTX_BYPASS_TLB_CACHE_EN <= 1'b0;
      XLAT_OFF_TLB_CACHE_EN <= 1'b0;
      NOMATCH_TLB_CACHE_EN <= 1'b0;
      STAGE1_WALK_CACHE2_EN <= 1'b1;
    end else begin
      MAP_PAGE_BYTES <= ctrl_r[`SACR_BIT_PAGE_SIZE] ? `SACR_PAGE_64K : `SACR_PAGE_4K;
      CTX_BYPASS_TLB_CACHE_EN <= ctrl_r[`SACR_BIT_CTX_BYP];
      XLAT_OFF_TLB_CACHE_EN <= ctrl_r[`SACR_BIT_XLAT_OFF];
      NOMATCH_TLB_CACHE_EN <= ctrl_r[`SACR_BIT_NOMATCH];
      STAGE1_WALK_CACHE2_EN <= ctrl_r[`SACR_BIT_WC2];
    end
  end

  // context register write permission; closed until software clears the lock
  always @(posedge CLK) begin
    if (!RESET_N) begin
      CTX_AUX_WRITABLE_SEC <= 1'b0;
      CTX_AUX_WRITABLE_NS <= 1'b0;
    end else begin
      CTX_AUX_WRITABLE_SEC <= ~ctrl_r[`SACR_BIT_CACHE_LOCK];
      // non-secure contexts also need their own lock clear
      CTX_AUX_WRITABLE_NS <= ~ctrl_r[`SACR_BIT_CACHE_LOCK] & ~NS_CACHE_LOCK;
    end
  end

  // attribute normalization; write-back passes untouched
  always @(posedge CLK) begin
    if (!RESET_N) begin
      ATTR_OUT <= 8'h00;
    end else begin
      // non-cacheable system-shared is 8'h44 here
      ATTR_OUT <= (normalize && !is_wb(ATTR_IN)) ? 8'h44 : ATTR_IN;
    end
  end

  // completion pulse and wrapping completion count for the status word
  always @(posedge CLK) begin
    if (!RESET_N) begin
      XLAT_OFF_DONE <= 1'b0;
      xlat_cnt_r <= 4'h0;
    end else begin
      XLAT_OFF_DONE <= timer_done;
      if (timer_done)
        xlat_cnt_r <= xlat_cnt_r + 4'h1;
    end
  end

endmodule

/* File: src/sacr_wstrb_merge.v */
// byte-lane merge of write data into a register value under a mask
`timescale 1ns/1ps
module sacr_wstrb_merge (
  // inputs
  input wire [31:0] old_val,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire [31:0] wmask,
  // merged value
  output wire [31:0] new_val
);
  wire [31:0] lane;
  // expand strobes to bit lanes
  assign lane = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}} & wmask;
  assign new_val = (old_val & ~lane) | (wdata & lane);
endmodule
